/* File: verilog/vsec_top.sv */
// vme byte swap datapath, write setup delay and bus error capture beside the pci-vme bridge
`timescale 1ns/1ps
`include "vsec_map.svh"

// Operation
// - separate swap enables for master transfers and for slave transfers
// - d16 swap exchanges the two bytes inside each 16-bit half
// - d32 swap fully reverses the four bytes of the word
// - d64 swap reverses bytes separately in each 32-bit half
// - swap only aligned d16, d32, d64 cycles and only when enabled
// - swap decode settles from address phase and data strobes, before read data is valid
// - write strobes held back about 50 ns on the first beat only
// - software may switch the write delay off when all cycles swap
// - bus errors detected on bridge-mastered cycles under enable control
// - detected bus error drives the bridge local interrupt zero
// - capture latches address, strobes, modifier, lword and write on error
// - capture runs only after arming, independent of interrupt enable
// - every readout read advances the read sequence by one, except in a cycle that also resets the sequence
// - control write with bit 1 returns the sequence to entry one
// - readout nibbles give address, lword, strobes, modifier, write in order
// - sequence wraps to the first entry after sixteen reads
// - readout bit 7 shows armed, bits 6-4 read zero
// - all captured address bits 31-1 are kept for every address size
// - control bits arm, reset sequence, abort; zero bits do nothing
module vsec_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic swap_master_en,
  input wire logic swap_slave_en,
  input wire logic wr_delay_dis,
  input wire logic berr_irq_en,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic vme_berr_n,
  input wire logic vme_as_n,
  input wire logic vme_write_n,
  input wire logic vme_lword_n,
  input wire logic [5:0] vme_am,
  input wire logic [31:1] vme_a,
  input wire logic [1:0] vme_ds_n_i,
  output logic [1:0] vme_ds_n_o,
  output logic vme_ds_oe,
  input wire logic [63:0] vme_d_i,
  output logic [63:0] vme_d_o,
  output logic vme_d_oe,
  input wire logic [1:0] bridge_ds_n,
  input wire logic bridge_is_master,
  input wire logic [63:0] bridge_d_i,
  output logic [63:0] bridge_d_o,
  output logic bridge_local_irq_zero
);

  localparam int unsigned PV = 46;
  localparam logic [2:0] WS_LOAD = 3'(`VSEC_WR_SETUP_CYC - 1);

  logic [PV-1:0] pin_s1_q;
  logic [PV-1:0] pin_s2_q;
  logic [63:0] vd_s1_q;
  logic [63:0] vd_s2_q;
  logic [63:0] bd_s1_q;
  logic [63:0] bd_s2_q;
  logic berr_n_s;
  logic as_n_s;
  logic write_n_s;
  logic lword_n_s;
  logic [5:0] am_s;
  logic [31:1] a_s;
  logic [1:0] bus_ds_n_s;
  logic [1:0] req_ds_n_s;
  logic master_s;
  vsec_pkg::vsec_swap_e mode_d;
  vsec_pkg::vsec_swap_e mode_q;
  logic swap_en;
  logic mblt;
  logic [63:0] to_bridge;
  logic [63:0] to_bus;
  vsec_pkg::vsec_wst_e wst_q;
  logic [2:0] wcnt_q;
  logic start_w;
  logic [1:0] ds_o_q;
  logic ds_oe_q;
  logic [63:0] vd_o_q;
  logic vd_oe_q;
  logic [63:0] bd_o_q;
  logic berr_prev_q;
  logic berr_fall;
  logic irq_q;

  vsec_cap_if cap_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // every bus and bridge pin goes through two flops; nothing reads the first stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= `VSEC_PIN_RST;
      pin_s2_q <= `VSEC_PIN_RST;
    end else begin
      pin_s1_q <= {vme_berr_n, vme_as_n, vme_write_n, vme_lword_n, vme_am, vme_a, vme_ds_n_i,
                   bridge_ds_n, bridge_is_master};
      pin_s2_q <= pin_s1_q;
    end
  end

  // data lanes in both directions, same two-flop treatment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vd_s1_q <= 64'h0;
      vd_s2_q <= 64'h0;
      bd_s1_q <= 64'h0;
      bd_s2_q <= 64'h0;
    end else begin
      vd_s1_q <= vme_d_i;
      vd_s2_q <= vd_s1_q;
      bd_s1_q <= bridge_d_i;
      bd_s2_q <= bd_s1_q;
    end
  end

  // unpack the synchronised pins
  assign berr_n_s = pin_s2_q[45];
  assign as_n_s = pin_s2_q[44];
  assign write_n_s = pin_s2_q[43];
  assign lword_n_s = pin_s2_q[42];
  assign am_s = pin_s2_q[41:36];
  assign a_s = pin_s2_q[35:5];
  assign bus_ds_n_s = pin_s2_q[4:3];
  assign req_ds_n_s = pin_s2_q[2:1];
  assign master_s = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // pick the enable that matches who owns the cycle
  assign swap_en = master_s ? swap_master_en : swap_slave_en;
  assign mblt = (am_s == `VSEC_AM_A64_MBLT) || (am_s == `VSEC_AM_A32N_MBLT) || (am_s == `VSEC_AM_A32S_MBLT) ||
                (am_s == `VSEC_AM_A24N_MBLT) || (am_s == `VSEC_AM_A24S_MBLT);

  // decode from modifier, lword, address and data strobes, which settle before the data does
  always_comb begin
    mode_d = vsec_pkg::VSEC_SW_NONE;
    if (swap_en && !as_n_s) begin
      if (mblt) begin
        mode_d = vsec_pkg::VSEC_SW_D64;
      end else if (req_ds_n_s == 2'h0 || bus_ds_n_s == 2'h0) begin
        if (!lword_n_s && !a_s[1]) begin
          mode_d = vsec_pkg::VSEC_SW_D32;
        end else if (lword_n_s) begin
          mode_d = vsec_pkg::VSEC_SW_D16;
        end
      end
    end
  end

  // mux setting is registered so both data directions see one stable choice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= vsec_pkg::VSEC_SW_NONE;
    end else begin
      mode_q <= mode_d;
    end
  end

  vsec_swap u_swap_rx (
    .mode (mode_q),
    .din (vd_s2_q),
    .dout (to_bridge)
  );

  vsec_swap u_swap_tx (
    .mode (mode_q),
    .din (bd_s2_q),
    .dout (to_bus)
  );

  // registered data and enables; bus is driven on master writes and slave reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vd_o_q <= 64'h0;
      bd_o_q <= 64'h0;
      vd_oe_q <= 1'b0;
    end else begin
      vd_o_q <= to_bus;
      bd_o_q <= to_bridge;
      vd_oe_q <= !as_n_s && (master_s ^ write_n_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first strobe of a master cycle; later beats of a block pass straight through
  assign start_w = (wst_q == vsec_pkg::VSEC_WS_IDLE) && master_s && !as_n_s && (req_ds_n_s != `VSEC_DS_IDLE);

  // setup delay on writes only; reads go through at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_q <= vsec_pkg::VSEC_WS_IDLE;
      wcnt_q <= 3'h0;
    end else begin
      case (wst_q)
        vsec_pkg::VSEC_WS_IDLE: begin
          if (start_w && !write_n_s && !wr_delay_dis) begin
            wst_q <= vsec_pkg::VSEC_WS_WAIT;
            wcnt_q <= WS_LOAD;
          end else if (start_w) begin
            wst_q <= vsec_pkg::VSEC_WS_PASS;
          end
        end
        vsec_pkg::VSEC_WS_WAIT: begin
          if (as_n_s) begin
            wst_q <= vsec_pkg::VSEC_WS_IDLE;
          end else if (wcnt_q == 3'h0) begin
            wst_q <= vsec_pkg::VSEC_WS_PASS;
          end else begin
            wcnt_q <= wcnt_q - 3'h1;
          end
        end
        vsec_pkg::VSEC_WS_PASS: begin
          if (as_n_s) begin
            wst_q <= vsec_pkg::VSEC_WS_IDLE;
          end
        end
        default: wst_q <= vsec_pkg::VSEC_WS_IDLE;
      endcase
    end
  end

  // strobes reach the bus only once passing; driven only while mastering
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ds_o_q <= `VSEC_DS_IDLE;
      ds_oe_q <= 1'b0;
    end else begin
      ds_o_q <= (wst_q == vsec_pkg::VSEC_WS_PASS) ? req_ds_n_s : `VSEC_DS_IDLE;
      ds_oe_q <= master_s && !as_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus error edge on our own cycles; interrupt follows the error level while enabled
  assign berr_fall = berr_prev_q && !berr_n_s && master_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      berr_prev_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      berr_prev_q <= berr_n_s;
      irq_q <= berr_irq_en && master_s && !berr_n_s;
    end
  end

  // capture sees the error edge whatever the interrupt enable says
  assign cap_bus.berr_evt = berr_fall;
  assign cap_bus.addr = a_s;
  assign cap_bus.ds_n = bus_ds_n_s;
  assign cap_bus.am = am_s;
  assign cap_bus.lword_n = lword_n_s;
  assign cap_bus.write_n = write_n_s;
  assign cap_bus.rd = io_rd;
  assign cap_bus.wr = io_wr;
  assign cap_bus.wdata = io_wdata;

  vsec_capture u_capture (
    .clk (clk),
    .rst_n (rst_n),
    .cbus (cap_bus.cap)
  );

  assign io_rdata = cap_bus.rdata;
  assign vme_ds_n_o = ds_o_q;
  assign vme_ds_oe = ds_oe_q;
  assign vme_d_o = vd_o_q;
  assign vme_d_oe = vd_oe_q;
  assign bridge_d_o = bd_o_q;
  assign bridge_local_irq_zero = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  a_swap_needs_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q != vsec_pkg::VSEC_SW_NONE) |-> $past(swap_en))
    else $error("swap applied without its enable");
  a_swap_d16_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == vsec_pkg::VSEC_SW_D16) |=> (bd_o_q[15:8] == $past(vd_s2_q[7:0])) &&
    (bd_o_q[31:24] == $past(vd_s2_q[23:16])))
    else $error("d16 lanes not exchanged");
  a_swap_d32_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == vsec_pkg::VSEC_SW_D32) |=> (vd_o_q[7:0] == $past(bd_s2_q[31:24])) &&
    (vd_o_q[23:16] == $past(bd_s2_q[15:8])))
    else $error("d32 bytes not reversed");
  a_swap_d64_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == vsec_pkg::VSEC_SW_D64) |=> (bd_o_q[63:56] == $past(vd_s2_q[39:32])) &&
    (bd_o_q[31:24] == $past(vd_s2_q[7:0])))
    else $error("d64 halves not reversed");
  a_master_swap_sel: assert property (@(posedge clk) disable iff (!rst_n)
    (master_s && !swap_master_en) |=> (mode_q == vsec_pkg::VSEC_SW_NONE))
    else $error("master swap enable ignored");
  a_write_setup_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (start_w && !write_n_s && !wr_delay_dis) |=> (vme_ds_n_o == `VSEC_DS_IDLE)[*3])
    else $error("write strobe not delayed");
  a_read_no_delay: assert property (@(posedge clk) disable iff (!rst_n)
    (start_w && write_n_s) |=> (wst_q == vsec_pkg::VSEC_WS_PASS))
    else $error("read cycle delayed");
  a_delay_off_pass: assert property (@(posedge clk) disable iff (!rst_n)
    (start_w && wr_delay_dis) |=> (wst_q == vsec_pkg::VSEC_WS_PASS))
    else $error("disabled write delay still applied");
  a_irq_on_berr: assert property (@(posedge clk) disable iff (!rst_n)
    (berr_fall && berr_irq_en) |=> bridge_local_irq_zero)
    else $error("bus error did not raise interrupt");

endmodule : vsec_top

/* File: verilog/vsec_map.svh */
// register bit positions, bus codes and timing counts of the vme swap and error capture block
`ifndef VSEC_MAP_SVH
`define VSEC_MAP_SVH

// clock and write data setup delay
`define VSEC_CLK_PERIOD_NS 20
`define VSEC_WR_SETUP_NS 50
`define VSEC_WR_SETUP_CYC ((`VSEC_WR_SETUP_NS + `VSEC_CLK_PERIOD_NS - 1) / `VSEC_CLK_PERIOD_NS)

// capture control register bits (write only)
`define VSEC_CTL_ARM 0
`define VSEC_CTL_RSEQ 1
`define VSEC_CTL_ABORT 2

// capture readout register
`define VSEC_RD_STATUS 7
`define VSEC_SEQ_RST 4'h0

// address modifier codes of 64-bit block cycles
`define VSEC_AM_A64_MBLT 6'h00
`define VSEC_AM_A32N_MBLT 6'h08
`define VSEC_AM_A32S_MBLT 6'h0C
`define VSEC_AM_A24N_MBLT 6'h38
`define VSEC_AM_A24S_MBLT 6'h3C

// idle levels of active low bus lines
`define VSEC_DS_IDLE 2'h3
`define VSEC_PIN_RST 46'h3FFF_FFFF_FFFE

`endif

/* File: verilog/vsec_pkg.sv */
// types shared by the vme swap and error capture block
package vsec_pkg;

  typedef enum logic [3:0] {
    VSEC_SW_NONE = 4'h1,
    VSEC_SW_D16 = 4'h2,
    VSEC_SW_D32 = 4'h4,
    VSEC_SW_D64 = 4'h8
  } vsec_swap_e;

  typedef enum logic [1:0] {
    VSEC_CAP_IDLE = 2'h1,
    VSEC_CAP_ARMED = 2'h2
  } vsec_cap_e;

  typedef enum logic [2:0] {
    VSEC_WS_IDLE = 3'h1,
    VSEC_WS_WAIT = 3'h2,
    VSEC_WS_PASS = 3'h4
  } vsec_wst_e;

endpackage : vsec_pkg

/* File: verilog/vsec_cap_if.sv */
// carrier between the bus side and the capture register logic
`timescale 1ns/1ps
interface vsec_cap_if;
  logic berr_evt;
  logic [31:1] addr;
  logic [1:0] ds_n;
  logic [5:0] am;
  logic lword_n;
  logic write_n;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic armed;

  modport bus (output berr_evt, addr, ds_n, am, lword_n, write_n, rd, wr, wdata, input rdata, armed);
  modport cap (input berr_evt, addr, ds_n, am, lword_n, write_n, rd, wr, wdata, output rdata, armed);
endinterface : vsec_cap_if

/* File: verilog/vsec_swap.sv */
// byte lane multiplexer for the three swap arrangements
`timescale 1ns/1ps
module vsec_swap (
  input wire vsec_pkg::vsec_swap_e mode,
  input wire logic [63:0] din,
  output logic [63:0] dout
);

  ////////////////////////////////////////////////////////////////////////////
  // each 32-bit half is handled alike; d32 uses the low half only on the bus
  for (genvar h = 0; h < 2; h++) begin : g_half
    logic [31:0] w;
    assign w = din[h*32 +: 32];
    always_comb begin
      case (mode)
        vsec_pkg::VSEC_SW_D16: dout[h*32 +: 32] = {w[23:16], w[31:24], w[7:0], w[15:8]};
        vsec_pkg::VSEC_SW_D32: dout[h*32 +: 32] = {w[7:0], w[15:8], w[23:16], w[31:24]};
        vsec_pkg::VSEC_SW_D64: dout[h*32 +: 32] = {w[7:0], w[15:8], w[23:16], w[31:24]};
        default: dout[h*32 +: 32] = w;
      endcase
    end
  end

endmodule : vsec_swap

/* File: verilog/vsec_capture.sv */
// bus error capture store, readout sequence and control decode
`timescale 1ns/1ps
`include "vsec_map.svh"
module vsec_capture (
  input wire logic clk,
  input wire logic rst_n,
  vsec_cap_if.cap cbus
);

  vsec_pkg::vsec_cap_e st_q;
  logic [31:1] addr_q;
  logic [1:0] ds_q;
  logic [5:0] am_q;
  logic lword_q;
  logic wr_q;
  logic [3:0] seq_q;
  logic [3:0] nib;
  logic [7:0] rdata_q;
  logic arm_w;
  logic abort_w;
  logic rseq_w;
  logic take_w;

  // writing zero to a bit does nothing, so every action is a one-bit strobe
  assign arm_w = cbus.wr && cbus.wdata[`VSEC_CTL_ARM];
  assign rseq_w = cbus.wr && cbus.wdata[`VSEC_CTL_RSEQ];
  assign abort_w = cbus.wr && cbus.wdata[`VSEC_CTL_ABORT];
  assign take_w = (st_q == vsec_pkg::VSEC_CAP_ARMED) && cbus.berr_evt && !abort_w;

  ////////////////////////////////////////////////////////////////////////////
  // abort beats arm; an arm in the cycle of a capture re-arms so it is not lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= vsec_pkg::VSEC_CAP_IDLE;
    end else if (abort_w) begin
      st_q <= vsec_pkg::VSEC_CAP_IDLE;
    end else if (arm_w) begin
      st_q <= vsec_pkg::VSEC_CAP_ARMED;
    end else if (take_w) begin
      st_q <= vsec_pkg::VSEC_CAP_IDLE;
    end
  end
  assign cbus.armed = (st_q == vsec_pkg::VSEC_CAP_ARMED);

  // snapshot is frozen once idle; abort wipes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 31'h0;
      ds_q <= 2'h0;
      am_q <= 6'h0;
      lword_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (abort_w) begin
      addr_q <= 31'h0;
      ds_q <= 2'h0;
      am_q <= 6'h0;
      lword_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (take_w) begin
      addr_q <= cbus.addr;
      ds_q <= cbus.ds_n;
      am_q <= cbus.am;
      lword_q <= cbus.lword_n;
      wr_q <= cbus.write_n;
    end
  end

  // sequence reset wins over an advance in the same cycle; 4 bits wrap after 16 reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= `VSEC_SEQ_RST;
    end else if (rseq_w) begin
      seq_q <= `VSEC_SEQ_RST;
    end else if (cbus.rd) begin
      seq_q <= seq_q + 4'h1;
    end
  end

  // nibble for the current read position; undefined slots read zero
  always_comb begin
    case (seq_q)
      4'h0: nib = addr_q[31:28];
      4'h1: nib = addr_q[27:24];
      4'h2: nib = addr_q[23:20];
      4'h3: nib = addr_q[19:16];
      4'h4: nib = addr_q[15:12];
      4'h5: nib = addr_q[11:8];
      4'h6: nib = addr_q[7:4];
      4'h7: nib = {addr_q[3:1], lword_q};
      4'h8: nib = {ds_q, am_q[5:4]};
      4'h9: nib = am_q[3:0];
      4'hA: nib = {wr_q, 3'h0};
      default: nib = 4'h0;
    endcase
  end

  // readout register, reserved bits 6-4 read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h0;
    end else begin
      rdata_q <= {st_q == vsec_pkg::VSEC_CAP_ARMED, 3'h0, nib};
    end
  end
  assign cbus.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  a_seq_advance_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (cbus.rd && !rseq_w) |=> (seq_q == 4'($past(seq_q) + 4'h1)))
    else $error("read sequence did not advance by one");
  a_seq_reset_first: assert property (@(posedge clk) disable iff (!rst_n)
    rseq_w |=> (seq_q == 4'h0) ##1 (rdata_q[3:0] == addr_q[31:28]))
    else $error("sequence reset did not return to first entry");
  a_arm_sets_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (arm_w && !abort_w) |=> cbus.armed ##1 rdata_q[`VSEC_RD_STATUS])
    else $error("arm did not show capture in progress");
  a_abort_clears_all: assert property (@(posedge clk) disable iff (!rst_n)
    abort_w |=> (!cbus.armed && addr_q == 31'h0 && am_q == 6'h0))
    else $error("abort left capture state or data");
  a_idle_holds_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (!cbus.armed && !cbus.wr) |=> $stable(addr_q) && $stable(am_q) && !cbus.armed)
    else $error("captured data changed while idle");
  a_berr_takes_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (cbus.armed && cbus.berr_evt && !cbus.wr) |=> (addr_q == $past(cbus.addr)) && !cbus.armed)
    else $error("bus error did not capture address");

endmodule : vsec_capture

/* File: verification/vsec_vme_model.sv */
// far side model: vme backplane master or slave plus the bridge strobes and data
`timescale 1ns/1ps
module vsec_vme_model (
  input wire logic clk,
  input wire logic [1:0] vme_ds_n_o,
  input wire logic vme_ds_oe,
  input wire logic [63:0] vme_d_o,
  input wire logic vme_d_oe,
  output logic vme_berr_n,
  output logic vme_as_n,
  output logic vme_write_n,
  output logic vme_lword_n,
  output logic [5:0] vme_am,
  output logic [31:1] vme_a,
  output logic [1:0] vme_ds_n_i,
  output logic [63:0] vme_d_i,
  output logic [1:0] bridge_ds_n,
  output logic bridge_is_master,
  output logic [63:0] bridge_d_i
);
  logic [1:0] ds_q;
  logic [63:0] d_q;

  ////////////////////////////////////////////////////////////////////////////////
  // shared lines resolve to whichever party enables its drivers
  assign vme_ds_n_i = vme_ds_oe ? vme_ds_n_o : ds_q;
  assign vme_d_i = vme_d_oe ? vme_d_o : d_q;

  ////////////////////////////////////////////////////////////////////////////////
  // released lines: pulled-up lines go high, the master flag drops, address, modifier and data invert so stale data never looks valid
  task automatic rel();
    vme_as_n <= 1'b1;
    ds_q <= 2'h3;
    vme_berr_n <= 1'b1;
    vme_write_n <= 1'b1;
    vme_lword_n <= 1'b1;
    bridge_ds_n <= 2'h3;
    bridge_is_master <= 1'b0;
    vme_am <= ~vme_am;
    vme_a <= ~vme_a;
    d_q <= ~d_q;
    bridge_d_i <= ~bridge_d_i;
  endtask : rel

  // one transfer held n edges, optionally ended by a bus error held 6 edges
  task automatic cyc(input logic mst, input logic [5:0] am, input logic [31:1] a, input logic lw,
    input logic wr_n, input logic [63:0] d, input logic be, input int n);
    @(posedge clk);
    bridge_is_master <= mst;
    vme_am <= am;
    vme_a <= a;
    vme_lword_n <= lw;
    vme_write_n <= wr_n;
    d_q <= d;
    bridge_d_i <= d;
    vme_as_n <= 1'b0;
    ds_q <= mst ? 2'h3 : 2'h0; // as master the block drives the strobes itself
    bridge_ds_n <= 2'h0;
    repeat (n) @(posedge clk);
    if (be) begin
      vme_berr_n <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : cyc

  // idle bus at time zero
  initial begin
    vme_am = 6'h00;
    vme_a = 31'h0;
    d_q = 64'h0;
    bridge_d_i = 64'h0;
    rel();
  end
endmodule : vsec_vme_model

/* File: verification/vme_swap_and_error_capture_bench.sv */
// self-checking bench of the vme swap and error capture block
`timescale 1ns/1ps
`include "vsec_map.svh"
`define VSEC_CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module vme_swap_and_error_capture_bench;
  localparam logic [63:0] DAT = 64'h0123_4567_89AB_CDEF;
  localparam logic [43:0] CAP = {31'h4B2D_E1A7, 1'b0, 2'h0, 6'h3D, 1'b1, 3'h0};
  logic clk, rst_n, swap_master_en, swap_slave_en, wr_delay_dis, berr_irq_en, io_rd, io_wr;
  logic vme_berr_n, vme_as_n, vme_write_n, vme_lword_n, vme_ds_oe, vme_d_oe;
  logic bridge_is_master, bridge_local_irq_zero;
  logic [7:0] io_wdata, io_rdata;
  logic [5:0] vme_am;
  logic [31:1] vme_a;
  logic [1:0] vme_ds_n_i, vme_ds_n_o, bridge_ds_n;
  logic [63:0] vme_d_i, vme_d_o, bridge_d_i, bridge_d_o;
  int num_errors = 0;
  int n_checks = 0;

  vsec_top vsec_top_inst (
    .clk, .rst_n, .swap_master_en, .swap_slave_en, .wr_delay_dis, .berr_irq_en, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .vme_berr_n, .vme_as_n, .vme_write_n, .vme_lword_n, .vme_am, .vme_a,
    .vme_ds_n_i, .vme_ds_n_o, .vme_ds_oe, .vme_d_i, .vme_d_o, .vme_d_oe, .bridge_ds_n,
    .bridge_is_master, .bridge_d_i, .bridge_d_o, .bridge_local_irq_zero
  );

  vsec_vme_model vsec_vme_model_inst (
    .clk, .vme_ds_n_o, .vme_ds_oe, .vme_d_o, .vme_d_oe, .vme_berr_n, .vme_as_n, .vme_write_n,
    .vme_lword_n, .vme_am, .vme_a, .vme_ds_n_i, .vme_d_i, .bridge_ds_n, .bridge_is_master, .bridge_d_i
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // byte reversal inside groups of w bytes, w of 1 leaves data untouched
  function automatic logic [63:0] rev(input logic [63:0] d, input int w);
    for (int i = 0; i < 8; i++) begin
      rev[8 * i +: 8] = d[8 * ((i / w) * w + w - 1 - i % w) +: 8];
    end
  endfunction : rev

  // control write, one-cycle pulse
  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    io_wr <= 1'b1;
    io_wdata <= v;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask : wr

  // readout read, sampled in its own cycle; the trailing edge keeps reads apart
  task automatic rd(output logic [7:0] v);
    @(posedge clk);
    io_rd <= 1'b1;
    @(posedge clk);
    v = io_rdata;
    io_rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // a24 master read ends in bus error; full readout including the wrap
  task automatic t_capture();
    logic [7:0] v;
    berr_irq_en <= 1'b1;
    wr(8'h01);
    repeat (3) @(posedge clk);
    `VSEC_CHK("armed status", 4'h8, io_rdata[7:4])
    vsec_vme_model_inst.cyc(1'b1, 6'h3D, 31'h4B2D_E1A7, 1'b0, 1'b1, DAT, 1'b1, 10);
    `VSEC_CHK("irq", 1'b1, bridge_local_irq_zero)
    `VSEC_CHK("idle status", 4'h0, io_rdata[7:4])
    vsec_vme_model_inst.rel();
    wr(8'h02);
    repeat (3) @(posedge clk);
    for (int k = 0; k < 17; k++) begin
      rd(v);
      `VSEC_CHK("nibble", (k % 16 < 11) ? CAP[43 - 4 * (k % 16) -: 4] : 4'h0, v[3:0])
    end
  endtask : t_capture

  // unarmed error keeps old data, slave error ignored, zero write inert, abort
  task automatic t_hold();
    berr_irq_en <= 1'b0;
    vsec_vme_model_inst.cyc(1'b1, 6'h09, 31'h7FFF_FFFE, 1'b1, 1'b0, DAT, 1'b1, 10);
    `VSEC_CHK("irq masked", 1'b0, bridge_local_irq_zero)
    vsec_vme_model_inst.rel();
    wr(8'h02);
    repeat (3) @(posedge clk);
    `VSEC_CHK("held capture", {4'h0, CAP[43:40]}, io_rdata)
    wr(8'h01);
    vsec_vme_model_inst.cyc(1'b0, 6'h09, 31'h0, 1'b0, 1'b1, DAT, 1'b1, 4);
    vsec_vme_model_inst.rel();
    wr(8'h00);
    repeat (3) @(posedge clk);
    `VSEC_CHK("slave error ignored", 1'b1, io_rdata[7])
    wr(8'h07);
    repeat (3) @(posedge clk);
    `VSEC_CHK("aborted", 8'h00, io_rdata)
  endtask : t_hold

  // one read transfer with the given enables; master reads land on the bridge side
  task automatic sw(input logic mst, input logic [5:0] am, input logic lw, input logic ms, input logic sl,
    input logic [63:0] e);
    swap_master_en <= ms;
    swap_slave_en <= sl;
    vsec_vme_model_inst.cyc(mst, am, 31'h0000_1000, lw, 1'b1, DAT, 1'b0, 10);
    `VSEC_CHK("swapped data", e, mst ? bridge_d_o : vme_d_o)
    vsec_vme_model_inst.rel();
  endtask : sw

  // strobe latency in edges from the start of a master transfer
  task automatic lat(input logic wr_n, input logic dis, output int k);
    wr_delay_dis <= dis;
    k = 0;
    fork
      vsec_vme_model_inst.cyc(1'b1, 6'h09, 31'h0000_1000, 1'b0, wr_n, DAT, 1'b0, 16);
      while (k < 16 && vme_ds_n_o !== 2'h0) begin
        @(posedge clk);
        k++;
      end
    join
    vsec_vme_model_inst.rel();
    // let the previous strobes go idle, or the next count stops at once on stale low strobes
    repeat (4) @(posedge clk);
  endtask : lat

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int kr;
    int kw;
    int kn;
    rst_n = 1'b0;
    {swap_master_en, swap_slave_en, wr_delay_dis, berr_irq_en, io_rd, io_wr} = 6'h00;
    io_wdata = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `VSEC_CHK("reset outputs", 13'h0018, {io_rdata, vme_ds_n_o, vme_ds_oe, vme_d_oe, bridge_local_irq_zero})
    t_capture();
    t_hold();
    sw(1'b1, 6'h09, 1'b0, 1'b1, 1'b0, rev(DAT, 4));
    sw(1'b1, 6'h09, 1'b1, 1'b1, 1'b0, rev(DAT, 2));
    sw(1'b1, 6'h08, 1'b0, 1'b1, 1'b0, rev(DAT, 4));
    sw(1'b1, 6'h09, 1'b0, 1'b0, 1'b1, DAT);
    sw(1'b0, 6'h09, 1'b0, 1'b1, 1'b0, DAT);
    sw(1'b0, 6'h09, 1'b0, 1'b0, 1'b1, rev(DAT, 4));
    lat(1'b1, 1'b0, kr);
    lat(1'b0, 1'b0, kw);
    lat(1'b0, 1'b1, kn);
    `VSEC_CHK("write setup delay", `VSEC_WR_SETUP_CYC, kw - kr)
    `VSEC_CHK("delay disabled", kr, kn)
    test_done();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : vme_swap_and_error_capture_bench
